// [design/build_config_discovery_regs.sv]
// Read-only bank of build configuration discovery registers on AXI4-Lite.
// Assumes one 100 MHz clock, asynchronous active-low reset, synchronous inputs.
//
// Summary of operation
// - Seven 32-bit registers, always present, never removed
// - Page-walk slots in bits 9:0, rest reserved
// - Config-walk slots in bits 2:0, rest reserved
// - Index generation mode in bit 0
// - Translation service value, 0x08E54, bits 3:0
// - Buffer unit count, 0x08E58, bits 5:0
// - Performance counter count, 0x08E5C, bits 5:0
// - Partition width register at 0x08E60 resets to build value
// - Every register resets to its build value
// - Partition width in bits 3:0, rest reserved
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module build_config_discovery_regs #(
    parameter logic [9:0] page_walk_slots_param    = discovery_pkg::PAGE_WALK_SLOTS_DEF,
    parameter logic [2:0] config_walk_slots_param  = discovery_pkg::CONFIG_WALK_SLOTS_DEF,
    parameter logic [0:0] cache_index_gen_param    = discovery_pkg::CACHE_INDEX_GEN_DEF,
    parameter logic [3:0] translation_service_param = discovery_pkg::XLATE_SVC_DEF,
    parameter logic [5:0] buffer_unit_count_param  = discovery_pkg::BUF_UNITS_DEF,
    parameter logic [5:0] perf_counter_count_param = discovery_pkg::PERF_COUNTERS_DEF,
    parameter logic [3:0] partition_id_width_param = discovery_pkg::PART_WIDTH_DEF
) (
    // Clock, reset, enable
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             ce,
    // Write address
    input  wire logic                             awvalid,
    output logic                                  awready,
    input  wire logic [discovery_pkg::ADDR_W-1:0] awaddr,
    // Write data
    input  wire logic                             wvalid,
    output logic                                  wready,
    // Write response
    output logic                                  bvalid,
    input  wire logic                             bready,
    output logic [1:0]                            bresp,
    // Read address
    input  wire logic                             arvalid,
    output logic                                  arready,
    input  wire logic [discovery_pkg::ADDR_W-1:0] araddr,
    // Read data
    output logic                                  rvalid,
    input  wire logic                             rready,
    output logic [discovery_pkg::DATA_W-1:0]      rdata,
    output logic [1:0]                            rresp
);

    // Read channel states
    typedef enum logic {
        rd_idle,
        rd_answer
    } read_state_e;

    logic                      rst_n_sync;
    read_state_e               rd_state;
    read_state_e               next_rd_state;
    discovery_pkg::disc_image_s image;
    discovery_pkg::read_beat_s beat;
    logic                      ar_take;
    logic                      r_done;
    logic                      ar_hit;

    // Reset release for the whole bank
    reset_sync u_reset_sync (
        .clk        (clk),
        .rst_n      (rst_n),
        .rst_n_sync (rst_n_sync)
    );

    // Writes reach no storage; the sink only completes the handshake
    axi_write_sink u_write_sink (
        .clk     (clk),
        .rst_n   (rst_n_sync),
        .ce      (ce),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp)
    );

    // Build values gathered into the image layout; a constant, so the reset branch loads no signal
    localparam discovery_pkg::disc_image_s image_reset = '{
        page_walk_slots:     page_walk_slots_param,
        config_walk_slots:   config_walk_slots_param,
        cache_index_gen:     cache_index_gen_param,
        translation_service: translation_service_param,
        buffer_unit_count:   buffer_unit_count_param,
        perf_counter_count:  perf_counter_count_param,
        partition_id_width:  partition_id_width_param
    };

    // Image takes the build values at reset and is never written afterwards,
    // so it is constant for a given build
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            image <= image_reset;
        end else if (ce) begin
            image <= image;
        end
    end

    // Read decode: word select, zero-filled reserved bits, error on a miss
    assign ar_take   = arvalid && arready;
    assign r_done    = rvalid && rready;
    assign ar_hit    = discovery_pkg::addr_mapped(araddr);
    assign beat.data = discovery_pkg::read_word(araddr, image);
    assign beat.resp = ar_hit ? discovery_pkg::RESP_OKAY : discovery_pkg::RESP_DECERR;

    // Read state sequence: one address, then its answer until taken
    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            rd_idle: begin
                if (ar_take) begin
                    next_rd_state = rd_answer;
                end
            end
            rd_answer: begin
                if (r_done) begin
                    next_rd_state = rd_idle;
                end
            end
            default: begin
                next_rd_state = rd_idle;
            end
        endcase
    end

    // Read state register
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rd_state <= rd_idle;
        end else if (ce) begin
            rd_state <= next_rd_state;
        end
    end

    // Read handshake flops track the state so the outputs come from flops
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            arready <= discovery_pkg::READY_RST;
            rvalid  <= discovery_pkg::VALID_RST;
        end else if (ce) begin
            arready <= (next_rd_state == rd_idle);
            rvalid  <= (next_rd_state == rd_answer);
        end
    end

    // Read payload captured with the address and held until taken
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rdata <= '0;
            rresp <= discovery_pkg::RESP_OKAY;
        end else if (ce && ar_take) begin
            rdata <= beat.data;
            rresp <= beat.resp;
        end
    end

endmodule : build_config_discovery_regs

// [design/discovery_pkg.sv]
// Constants, carrier types and decode functions for the discovery register bank.
// Assumes a 32-bit AXI4-Lite slave port with 16-bit byte addresses.
package discovery_pkg;

    // Bus shape
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [15:0] OFF_PAGE_WALK_SLOT   = 16'h8e48;
    localparam logic [15:0] OFF_CONFIG_WALK_SLOT = 16'h8e4c;
    localparam logic [15:0] OFF_CACHE_INDEX_GEN  = 16'h8e50;
    localparam logic [15:0] OFF_TRANSLATION_SVC  = 16'h8e54;
    localparam logic [15:0] OFF_BUFFER_UNITS     = 16'h8e58;
    localparam logic [15:0] OFF_PERF_COUNTERS    = 16'h8e5c;
    localparam logic [15:0] OFF_PARTITION_WIDTH  = 16'h8e60;

    // Field widths, each field sits at bit 0
    localparam int PAGE_WALK_W   = 10;
    localparam int CONFIG_WALK_W = 3;
    localparam int CACHE_GEN_W   = 1;
    localparam int XLATE_SVC_W   = 4;
    localparam int BUF_UNITS_W   = 6;
    localparam int PERF_CNT_W    = 6;
    localparam int PART_WIDTH_W  = 4;

    // Default build values, also the reset values of the image
    localparam logic [9:0] PAGE_WALK_SLOTS_DEF   = 10'h200;
    localparam logic [2:0] CONFIG_WALK_SLOTS_DEF = 3'h4;
    localparam logic [0:0] CACHE_INDEX_GEN_DEF   = 1'h0;
    localparam logic [3:0] XLATE_SVC_DEF         = 4'h8;
    localparam logic [5:0] BUF_UNITS_DEF         = 6'h01;
    localparam logic [5:0] PERF_COUNTERS_DEF     = 6'h20;
    localparam logic [3:0] PART_WIDTH_DEF        = 4'h9;

    // Response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Reset values of the bus handshake flops
    localparam logic READY_RST = 1'b1;
    localparam logic VALID_RST = 1'b0;

    // Held copy of every build value the bank reports
    typedef struct packed {
        logic [PAGE_WALK_W-1:0]   page_walk_slots;
        logic [CONFIG_WALK_W-1:0] config_walk_slots;
        logic [CACHE_GEN_W-1:0]   cache_index_gen;
        logic [XLATE_SVC_W-1:0]   translation_service;
        logic [BUF_UNITS_W-1:0]   buffer_unit_count;
        logic [PERF_CNT_W-1:0]    perf_counter_count;
        logic [PART_WIDTH_W-1:0]  partition_id_width;
    } disc_image_s;

    // One read answer
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0]        resp;
    } read_beat_s;

    // True when the word address hits one of the seven registers
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [13:0] w;
        w = a[15:2];
        addr_mapped = (w == OFF_PAGE_WALK_SLOT[15:2])   || (w == OFF_CONFIG_WALK_SLOT[15:2]) ||
                      (w == OFF_CACHE_INDEX_GEN[15:2])  || (w == OFF_TRANSLATION_SVC[15:2])  ||
                      (w == OFF_BUFFER_UNITS[15:2])     || (w == OFF_PERF_COUNTERS[15:2])    ||
                      (w == OFF_PARTITION_WIDTH[15:2]);
    endfunction : addr_mapped

    // Read word for an address; reserved bits and unmapped words read zero
    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input disc_image_s img);
        logic [13:0] w;
        w = a[15:2];
        read_word = 32'h0;
        if (w == OFF_PAGE_WALK_SLOT[15:2]) begin
            read_word = {22'h0, img.page_walk_slots};
        end else if (w == OFF_CONFIG_WALK_SLOT[15:2]) begin
            read_word = {29'h0, img.config_walk_slots};
        end else if (w == OFF_CACHE_INDEX_GEN[15:2]) begin
            read_word = {31'h0, img.cache_index_gen};
        end else if (w == OFF_TRANSLATION_SVC[15:2]) begin
            read_word = {28'h0, img.translation_service};
        end else if (w == OFF_BUFFER_UNITS[15:2]) begin
            read_word = {26'h0, img.buffer_unit_count};
        end else if (w == OFF_PERF_COUNTERS[15:2]) begin
            read_word = {26'h0, img.perf_counter_count};
        end else if (w == OFF_PARTITION_WIDTH[15:2]) begin
            read_word = {28'h0, img.partition_id_width};
        end
    endfunction : read_word

endpackage : discovery_pkg

// [design/reset_sync.sv]
// Two-flop release synchroniser for the active-low reset.
// Assumes rst_n may assert at any time; release is taken on clk.
`timescale 1ns/1ps
module reset_sync (
    // Clock and raw reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Synchronised reset
    output logic      rst_n_sync
);

    logic stage;

    // Assert at once, release after two edges; not gated by the clock enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage      <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            stage      <= 1'b1;
            rst_n_sync <= stage;
        end
    end

endmodule : reset_sync

// [design/axi_write_sink.sv]
// AXI4-Lite write channels for a read-only bank: takes address and data in
// either order, stores nothing, answers once both have arrived.
// Assumes the synchronised reset and a shared clock enable.
`timescale 1ns/1ps
module axi_write_sink (
    // Clock, reset, enable
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             ce,
    // Write address
    input  wire logic                             awvalid,
    output logic                                  awready,
    input  wire logic [discovery_pkg::ADDR_W-1:0] awaddr,
    // Write data
    input  wire logic                             wvalid,
    output logic                                  wready,
    // Write response
    output logic                                  bvalid,
    input  wire logic                             bready,
    output logic [1:0]                            bresp
);

    logic [discovery_pkg::ADDR_W-1:0] held_addr;
    logic                             aw_take;
    logic                             w_take;
    logic                             both_in;
    logic                             b_done;

    // Handshake decode
    assign aw_take = awvalid && awready;
    assign w_take  = wvalid && wready;
    assign both_in = !awready && !wready && !bvalid;
    assign b_done  = bvalid && bready;

    // Address side: closes after capture, reopens after the response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready   <= discovery_pkg::READY_RST;
            held_addr <= '0;
        end else if (ce) begin
            if (aw_take) begin
                awready   <= 1'b0;
                held_addr <= awaddr;
            end else if (b_done) begin
                awready   <= 1'b1;
            end
        end
    end

    // Data side: the data beat is dropped, the bank holds nothing writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wready <= discovery_pkg::READY_RST;
        end else if (ce) begin
            if (w_take) begin
                wready <= 1'b0;
            end else if (b_done) begin
                wready <= 1'b1;
            end
        end
    end

    // Response: OKAY on a mapped word without side effect, DECERR elsewhere
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= discovery_pkg::VALID_RST;
            bresp  <= discovery_pkg::RESP_OKAY;
        end else if (ce) begin
            if (both_in) begin
                bvalid <= 1'b1;
                bresp  <= discovery_pkg::addr_mapped(held_addr) ? discovery_pkg::RESP_OKAY
                                                                : discovery_pkg::RESP_DECERR;
            end else if (b_done) begin
                bvalid <= 1'b0;
            end
        end
    end

endmodule : axi_write_sink

// [verification/discovery_props.sv]
// Concurrent checks on the bus ports of the discovery register bank.
// Assumes it is bound to build_config_discovery_regs and sees only its ports.
`timescale 1ns/1ps
module discovery_props (
    // Clock, reset, enable
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    // Write channels
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    // Read channels
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Address and data taken at one edge, then readies drop and a response follows
    sequence both_taken;
        awvalid && awready && wvalid && wready && ce;
    endsequence
    sequence resp_after;
        !awready && !wready ##1 bvalid;
    endsequence

    a_write_resp_time: assert property (both_taken |=> resp_after)
        else $error("write response not two cycles after both handshakes");
    a_read_next: assert property (arvalid && arready && ce |=> rvalid && !arready)
        else $error("read data not valid one cycle after address");
    a_read_hold: assert property (rvalid && !(rready && ce) |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before it was taken");
    a_read_close: assert property (rvalid && rready && ce |=> !rvalid && arready)
        else $error("read channel did not reopen after data taken");
    a_write_hold: assert property (bvalid && !(bready && ce) |=> bvalid && $stable(bresp))
        else $error("write response changed before it was taken");
    a_write_block: assert property (bvalid |-> !awready && !wready)
        else $error("write channel open while response pending");
    a_reserved_zero: assert property (rvalid |-> rdata[31:10] == 22'h0)
        else $error("reserved read bits not zero");
    a_decerr_empty: assert property (rvalid && rresp != 2'h0 |-> rresp == 2'h3 && rdata == 32'h0)
        else $error("error response with data or bad code");
    a_ce_freeze: assert property (!ce |=> $stable(rvalid) && $stable(bvalid) && $stable(arready))
        else $error("state moved while clock enable low");
endmodule : discovery_props

bind build_config_discovery_regs discovery_props u_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
);

// [verification/tb_build_config_discovery_regs.sv]
// Self-checking bench for the discovery register bank over AXI4-Lite.
// Assumes the package is compiled first and the checker is bound to the design.
`timescale 1ns/1ps
module tb_build_config_discovery_regs;
    logic        clk, rst_n, ce;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [15:0] awaddr, araddr;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, seen_d;
    logic [1:0]  seen_r;
    logic [15:0] rnd, a;
    int          fail_count, num_checks, cycles, i;
    logic [15:0] offs [7] = '{16'h8e48, 16'h8e4c, 16'h8e50, 16'h8e54, 16'h8e58, 16'h8e5c, 16'h8e60};

    // Design built with non-default values so fixed answers show up; two fields keep their defaults
    build_config_discovery_regs #(.page_walk_slots_param(10'h2a5), .config_walk_slots_param(3'h1),
        .cache_index_gen_param(1'h1), .buffer_unit_count_param(6'h3e),
        .partition_id_width_param(4'h5)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));

    // Reference model of the register image
    function automatic logic [32:0] model(input logic [15:0] x);
        case ({x[15:2], 2'b00})
            16'h8e48: model = {1'b1, 32'h2a5};
            16'h8e4c: model = {1'b1, 32'h1};
            16'h8e50: model = {1'b1, 32'h1};
            16'h8e54: model = {1'b1, 32'h8};
            16'h8e58: model = {1'b1, 32'h3e};
            16'h8e5c: model = {1'b1, 32'h20};
            16'h8e60: model = {1'b1, 32'h5};
            default:  model = 33'h0;
        endcase
    endfunction : model

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // Read one word; rready stalls for a while, ce may freeze the request first
    task automatic rd(input logic [15:0] x, input int stall, input bit freeze);
        int n;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr  <= x;
        if (freeze) begin
            ce <= 1'b0;
            repeat (3) @(posedge clk);
            chk("rvalid_frozen", {31'h0, rvalid}, 32'h0);
            ce <= 1'b1;
        end
        do @(posedge clk); while (!(arready && ce));
        arvalid <= 1'b0;
        rready  <= (stall == 0);
        n = 0;
        forever begin
            @(posedge clk);
            if (rvalid && rready) break;
            n++;
            if (n >= stall) rready <= 1'b1;
        end
        seen_d = rdata;
        seen_r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Write one word, address and data offered together; bready may wait for bvalid
    task automatic wr(input logic [15:0] x, input bit b_stall);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr  <= x;
        wvalid  <= 1'b1;
        bready  <= !b_stall;
        forever begin
            @(posedge clk);
            if (bvalid && bready) break;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end
        seen_r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] x, input int stall, input bit freeze);
        logic [32:0] m;
        m = model(x);
        rd(x, stall, freeze);
        chk("rdata", seen_d, m[31:0]);
        chk("rresp", {30'h0, seen_r}, m[32] ? 32'h0 : 32'h3);
    endtask : rd_chk

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {ce, awaddr, araddr, rnd} = {1'b1, 32'h0, 16'd6736};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Every register read, written, and read back unchanged
        for (i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            rd_chk(offs[i], rnd[1:0], i == 0);
            wr(offs[i] | {14'h0, rnd[3:2]}, rnd[4]);
            chk("bresp", {30'h0, seen_r}, 32'h0);
            rd_chk(offs[i], 0, 0);
        end
        // Unmapped neighbours and random addresses
        for (i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            a = (i == 0) ? 16'h8e44 : (i == 1) ? 16'h8e64 : rnd;
            rd_chk(a, rnd[1:0], 0);
            wr(a, rnd[5]);
            chk("bresp", {30'h0, seen_r}, model(a) >> 32 ? 32'h0 : 32'h3);
        end
        // Reset in mid-run returns the build values
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rvalid_rst", {31'h0, rvalid}, 32'h0);
        chk("ready_rst", {29'h0, arready, awready, wready}, 32'h7);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(16'h8e60, 1, 0);
        rd_chk(16'h8e48, 0, 0);
        conclude();
    end
endmodule : tb_build_config_discovery_regs
